// *** rtl/gudc_pkg.sv ***
package gudc_pkg;

	// ==========================================================
	// register map (byte addresses, one word each)
	// ==========================================================
	localparam logic [2:0] IDX_CTRL   = 3'h0; // 0x00 control
	localparam logic [2:0] IDX_LOAD   = 3'h1; // 0x04 initial count
	localparam logic [2:0] IDX_DELAY  = 3'h2; // 0x08 pulse delay, source periods
	localparam logic [2:0] IDX_PWIDTH = 3'h3; // 0x0c pulse width, source periods
	localparam logic [2:0] IDX_COUNT  = 3'h4; // 0x10 live count
	localparam logic [2:0] IDX_SAVE   = 3'h5; // 0x14 save register
	localparam logic [2:0] IDX_STATUS = 3'h6; // 0x18 status
	localparam logic [2:0] IDX_STREAM = 3'h7; // 0x1c stream head, read pops

	// ==========================================================
	// control field positions
	// ==========================================================
	localparam int CTL_ARM      = 0;  // arm the counter
	localparam int CTL_MODE     = 1;  // [2:1] application
	localparam int CTL_DIR_HW   = 3;  // direction from pin
	localparam int CTL_DIR_UP   = 4;  // software direction, 1 = up
	localparam int CTL_GATE     = 5;  // [6:5] gate use
	localparam int CTL_TRIG     = 7;  // start trigger / gated pulse
	localparam int CTL_EVERY    = 8;  // retrigger on every gate edge
	localparam int CTL_SRC_POL  = 9;  // 1 = falling source edge active
	localparam int CTL_GATE_POL = 10; // 1 = falling gate edge / low level active
	localparam int CTL_BUF      = 11; // buffered gate mode

	localparam logic [1:0] MODE_EVT   = 2'h0;
	localparam logic [1:0] MODE_PULSE = 2'h1;
	localparam logic [1:0] GATE_NONE  = 2'h0;
	localparam logic [1:0] GATE_LVL   = 2'h1;
	localparam logic [1:0] GATE_SAVE  = 2'h2;

	// status bits
	localparam int STS_OUT     = 0;
	localparam int STS_STATE   = 1; // [3:1]
	localparam int STS_VALID   = 4;
	localparam int STS_OVERRUN = 5; // write one to clear

	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_WAIT = 3'h1,
		ST_RUN  = 3'h3,
		ST_PDLY = 3'h2,
		ST_PHI  = 3'h6,
		ST_DONE = 3'h7
	} gudc_state_e;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] load;
		logic [31:0] delay;
		logic [31:0] pwidth;
		logic [31:0] cnt;
		logic [31:0] save;
		logic [31:0] stream;
		logic [31:0] pcnt;
		logic [31:0] res;
		logic [31:0] hrdata;
		logic        stream_vld;
		logic        overrun;
		logic        res_vld;
		logic        out;
		gudc_state_e state;
		logic        a_wr;
		logic [2:0]  a_idx;
		logic [2:0]  ff1;
		logic [2:0]  ff2;
		logic [2:0]  ff3;
	} gudc_st_s;

endpackage : gudc_pkg

// *** rtl/gudc_counter.sv ***
// The AHB-Lite register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
// Overview of operation
// - width parameter 16, 24 or 32; direction pin only on 24/32.
// - each active source edge moves the count by one, up or down.
// - gate bounds counting intervals or copies count into save register.
// - hardware direction: pin high counts up, pin low counts down.
// - pulse generation uses source edges as its timebase.
// - pulse delay and width are counted in whole source periods.
// - gated pulse fires after the first gate edge or after every one.
// - buffered gate mode latches each result into save register per edge.
// - buffered results stream to the host with a request line.
// - non-buffered gate mode presents the result at every gate edge.
// - with start trigger wait for gate edge, otherwise run at arming.
module gudc_counter
	import gudc_pkg::*;
#(
	parameter int WIDTH = 32 // 16, 24 or 32
)(
	input  wire logic        hclk,      // bus clock
	input  wire logic        hresetn,   // async reset, low
	input  wire logic        hsel,      // slave select
	input  wire logic [31:0] haddr,     // byte address
	input  wire logic [1:0]  htrans,    // transfer type
	input  wire logic        hwrite,    // write
	input  wire logic [2:0]  hsize,     // word only
	input  wire logic [31:0] hwdata,    // write data
	input  wire logic        hready,    // bus ready
	output logic      [31:0] hrdata,    // read data
	output logic             hreadyout, // always ready
	output logic             hresp,     // always okay
	input  wire logic        src_pin,   // source input
	input  wire logic        gate_pin,  // gate input
	input  wire logic        updn_pin,  // count direction input
	output logic             out_pin,   // counter output
	output logic      [31:0] res_data,  // non-buffered result
	output logic             res_vld,   // result strobe
	output logic             stream_req // buffered result waiting
);

	// ==========================================================
	// helpers
	// ==========================================================
	localparam logic [31:0] MASK = (WIDTH >= 32) ? 32'hffff_ffff
		: 32'((64'h1 << WIDTH) - 64'h1);
	localparam bit HAS_DIR = (WIDTH > 16);

	function automatic logic [31:0] wrap_f(input logic [31:0] v);
		return v & MASK;
	endfunction : wrap_f

	function automatic logic is_idx_f(input logic [2:0] a, input logic [2:0] b);
		return a == b;
	endfunction : is_idx_f

	gudc_st_s r;
	gudc_st_s n;

	logic        src_e;
	logic        gate_e;
	logic        gate_lvl;
	logic        dir_up;
	logic        counting;
	logic        gate_act;
	logic        a_take;
	logic        a_map;
	logic [31:0] rd_word;
	logic        pop;
	logic        arm_wr;
	logic        disarm_wr;
	logic [1:0]  mode;
	logic [1:0]  gate_use;

	// ==========================================================
	// pin conditioning
	// ==========================================================
	// edges are taken from the second and third stages only
	assign src_e    = (r.ff2[0] ^ r.ctrl[CTL_SRC_POL]) & ~(r.ff3[0] ^ r.ctrl[CTL_SRC_POL]);
	assign gate_e   = (r.ff2[1] ^ r.ctrl[CTL_GATE_POL]) & ~(r.ff3[1] ^ r.ctrl[CTL_GATE_POL]);
	assign gate_lvl = r.ff2[1] ^ r.ctrl[CTL_GATE_POL];
	assign mode     = r.ctrl[CTL_MODE +: 2];
	assign gate_use = r.ctrl[CTL_GATE +: 2];
	// narrow counter has no direction pin, so software bit rules
	assign dir_up   = (HAS_DIR && r.ctrl[CTL_DIR_HW]) ? r.ff2[2]
		: r.ctrl[CTL_DIR_UP];
	assign counting = (r.state == ST_RUN) && (mode == MODE_EVT) && src_e
		&& ((gate_use != GATE_LVL) || gate_lvl);
	assign gate_act = (r.state == ST_RUN) && (mode == MODE_EVT)
		&& (gate_use == GATE_SAVE) && gate_e;

	// ==========================================================
	// bus decode
	// ==========================================================
	assign a_take    = hsel && htrans[1] && hready;
	assign a_map     = (haddr[31:5] == 27'h0);
	assign pop       = a_take && !hwrite && a_map && is_idx_f(haddr[4:2], IDX_STREAM);
	assign arm_wr    = r.a_wr && is_idx_f(r.a_idx, IDX_CTRL) && hwdata[CTL_ARM]
		&& !r.ctrl[CTL_ARM];
	assign disarm_wr = r.a_wr && is_idx_f(r.a_idx, IDX_CTRL) && !hwdata[CTL_ARM];

	always_comb
	begin
		rd_word = RST_WORD;
		case (haddr[4:2])
			IDX_CTRL:   rd_word = r.ctrl;
			IDX_LOAD:   rd_word = r.load;
			IDX_DELAY:  rd_word = r.delay;
			IDX_PWIDTH: rd_word = r.pwidth;
			IDX_COUNT:  rd_word = r.cnt;
			IDX_SAVE:   rd_word = r.save;
			IDX_STATUS:
			begin
				rd_word[STS_OUT]         = r.out;
				rd_word[STS_STATE +: 3]  = r.state;
				rd_word[STS_VALID]       = r.stream_vld;
				rd_word[STS_OVERRUN]     = r.overrun;
			end
			IDX_STREAM: rd_word = r.stream;
			default:    rd_word = RST_WORD;
		endcase
		if (!a_map)
			rd_word = RST_WORD;
	end

	// ==========================================================
	// next state
	// ==========================================================
	always_comb
	begin
		n         = r;
		n.ff1     = {updn_pin, gate_pin, src_pin};
		n.ff2     = r.ff1;
		n.ff3     = r.ff2;
		n.res_vld = 1'b0;
		n.a_wr    = a_take && hwrite && a_map;
		n.a_idx   = haddr[4:2];
		if (a_take && !hwrite)
			n.hrdata = rd_word;
		if (pop)
			n.stream_vld = 1'b0;

		case (r.state)
			ST_IDLE:
				n.out = 1'b0;
			ST_WAIT:
				if (gate_e)
				begin
					n.state = (mode == MODE_PULSE) ? ST_PDLY : ST_RUN;
					n.pcnt  = r.delay;
				end
			ST_RUN:
			begin
				if (counting)
					n.cnt = dir_up ? wrap_f(r.cnt + 32'h1)
						: wrap_f(r.cnt - 32'h1);
				if (gate_act)
				begin
					n.save = r.cnt;
					if (r.ctrl[CTL_BUF])
					begin
						n.stream     = r.cnt;
						n.stream_vld = 1'b1;
						if (r.stream_vld && !pop)
							n.overrun = 1'b1; // lost an older result
					end
					else
					begin
						n.res     = r.cnt;
						n.res_vld = 1'b1;
					end
				end
			end
			ST_PDLY:
				if (src_e)
				begin
					n.pcnt = r.pcnt - 32'h1;
					if (r.pcnt <= 32'h1)
					begin
						n.state = ST_PHI;
						n.out   = 1'b1;
						n.pcnt  = r.pwidth;
					end
				end
			ST_PHI:
				if (src_e)
				begin
					n.pcnt = r.pcnt - 32'h1;
					if (r.pcnt <= 32'h1)
					begin
						n.out   = 1'b0;
						n.state = (r.ctrl[CTL_TRIG] && r.ctrl[CTL_EVERY]) ? ST_WAIT
							: ST_DONE;
					end
				end
			ST_DONE:
				n.out = 1'b0;
			default:
				n.state = ST_IDLE;
		endcase

		// register writes, data phase
		if (r.a_wr)
		begin
			case (r.a_idx)
				IDX_CTRL:   n.ctrl   = hwdata;
				IDX_LOAD:   n.load   = wrap_f(hwdata);
				IDX_DELAY:  n.delay  = hwdata;
				IDX_PWIDTH: n.pwidth = hwdata;
				IDX_STATUS:
					if (hwdata[STS_OVERRUN] && !(gate_act && r.ctrl[CTL_BUF] && r.stream_vld && !pop))
						n.overrun = 1'b0; // a new overrun beats the clear
				default:    n.overrun = n.overrun;
			endcase
		end
		if (arm_wr)
		begin
			n.cnt  = r.load;
			n.out  = 1'b0;
			n.pcnt = r.delay;
			if (hwdata[CTL_TRIG])
				n.state = ST_WAIT;
			else
				n.state = (hwdata[CTL_MODE +: 2] == MODE_PULSE) ? ST_PDLY : ST_RUN;
		end
		else if (disarm_wr)
		begin
			n.state = ST_IDLE;
			n.out   = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			r <= '0;
		else
			r <= n;
	end

	assign hrdata     = r.hrdata;
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign out_pin    = r.out;
	assign res_data   = r.res;
	assign res_vld    = r.res_vld;
	assign stream_req = r.stream_vld;

	// ==========================================================
	// assertions
	// ==========================================================
	count_up_a: assert property (@(posedge hclk) disable iff (!hresetn)
		counting && dir_up && !arm_wr |=> r.cnt == wrap_f($past(r.cnt) + 32'h1))
		else $error("count did not step up by one");

	count_down_a: assert property (@(posedge hclk) disable iff (!hresetn)
		counting && !dir_up && !arm_wr |=> r.cnt == wrap_f($past(r.cnt) - 32'h1))
		else $error("count did not step down by one");

	sw_dir_a: assert property (@(posedge hclk) disable iff (!hresetn)
		counting && !(HAS_DIR && r.ctrl[CTL_DIR_HW]) && !arm_wr
		|=> r.cnt == wrap_f($past(r.cnt) + ($past(r.ctrl[CTL_DIR_UP]) ? 32'h1 : 32'hffff_ffff)))
		else $error("direction not taken from control");

	wrap_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(r.cnt & ~MASK) == 32'h0)
		else $error("count exceeds counter width");

	level_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_RUN && gate_use == GATE_LVL && !gate_lvl && !r.a_wr
		|=> r.cnt == $past(r.cnt))
		else $error("counted outside gate interval");

	save_latch_a: assert property (@(posedge hclk) disable iff (!hresetn)
		gate_act |=> r.save == $past(r.cnt))
		else $error("save register missed gate edge");

	stream_push_a: assert property (@(posedge hclk) disable iff (!hresetn)
		gate_act && r.ctrl[CTL_BUF] |=> stream_req && r.stream == $past(r.cnt))
		else $error("buffered result not offered");

	nobuf_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
		gate_act && !r.ctrl[CTL_BUF] |=> res_vld && res_data == $past(r.cnt))
		else $error("unbuffered result not presented");

	trig_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_WAIT && !gate_e && !r.a_wr |=> r.state == ST_WAIT)
		else $error("left trigger wait without gate edge");

	pulse_time_a: assert property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_PDLY && !src_e && !r.a_wr |=> r.state == ST_PDLY && !out_pin)
		else $error("pulse delay moved without source edge");

	pulse_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_PDLY && src_e && r.pcnt <= 32'h1 && !r.a_wr
		|=> out_pin ##0 r.pcnt == $past(r.pwidth))
		else $error("pulse did not start after delay");

	first_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_PHI && src_e && r.pcnt <= 32'h1 && !r.ctrl[CTL_EVERY] && !r.a_wr
		|=> r.state == ST_DONE)
		else $error("single gated pulse retriggered");

	overrun_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		gate_act && r.ctrl[CTL_BUF] && r.stream_vld && !pop |=> r.overrun)
		else $error("lost result did not flag overrun");

	stream_pop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		pop && !(gate_act && r.ctrl[CTL_BUF]) |=> !stream_req)
		else $error("stream request survived a pop");

	arm_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
		arm_wr |=> r.cnt == $past(r.load) && r.state != ST_IDLE)
		else $error("arming did not load the count");

	arm_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		arm_wr && !hwdata[CTL_TRIG] && hwdata[CTL_MODE +: 2] == MODE_EVT |=> r.state == ST_RUN)
		else $error("untriggered count did not start at arming");

	res_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
		res_vld |=> !res_vld)
		else $error("result strobe longer than one cycle");

	gate_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_WAIT && gate_e && mode == MODE_PULSE && !r.a_wr
		|=> r.state == ST_PDLY && r.pcnt == $past(r.delay))
		else $error("gate edge did not start pulse delay");

	idle_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_IDLE && !r.a_wr |=> r.cnt == $past(r.cnt) && !out_pin)
		else $error("idle counter moved");

	dly_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_PDLY && src_e && r.pcnt > 32'h1 && !r.a_wr
		|=> r.state == ST_PDLY && r.pcnt == $past(r.pcnt) - 32'h1)
		else $error("delay did not step by one source period");

	pulse_c: cover property (@(posedge hclk) disable iff (!hresetn)
		r.state == ST_PHI ##1 r.state == ST_WAIT);
	buffered_c: cover property (@(posedge hclk) disable iff (!hresetn)
		gate_act && r.ctrl[CTL_BUF] ##1 pop);
	wrap_c: cover property (@(posedge hclk) disable iff (!hresetn)
		counting && !dir_up && r.cnt == 32'h0);
	overrun_c: cover property (@(posedge hclk) disable iff (!hresetn)
		$rose(r.overrun));

endmodule : gudc_counter

// *** dv/gudc_pins.sv ***
`timescale 1ns/1ps
module gudc_pins (
	input  wire logic hclk,     // bus clock
	output logic      src_pin,  // source events
	output logic      gate_pin, // gate events
	output logic      updn_pin  // direction level
);
	// ==========================================================
	// event drivers
	// ==========================================================
	initial
	begin
		src_pin  = 1'b0;
		gate_pin = 1'b0;
		updn_pin = 1'b1;
	end

	// three clocks per level so the synchroniser never drops an edge
	task automatic hold3();
		repeat (3) @(posedge hclk);
	endtask : hold3

	task automatic src_pulses(input int n);
		repeat (n)
		begin
			src_pin <= 1'b1;
			hold3();
			src_pin <= 1'b0;
			hold3();
		end
	endtask : src_pulses

	task automatic gate_pulse();
		gate_pin <= 1'b1;
		hold3();
		gate_pin <= 1'b0;
		hold3();
	endtask : gate_pulse

	task automatic gate_set(input logic v);
		gate_pin <= v;
		hold3();
	endtask : gate_set

	task automatic set_dir(input logic up);
		updn_pin <= up;
		hold3();
	endtask : set_dir
endmodule : gudc_pins

// *** dv/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	import gudc_pkg::*;
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic        src_pin;
	logic        gate_pin;
	logic        updn_pin;
	logic        out_pin;
	logic [31:0] res_data;
	logic        res_vld;
	logic        stream_req;
	logic [31:0] res_seen;
	logic [31:0] rd;
	int          n_mismatch;
	int          checks;

	gudc_counter #(.WIDTH(32)) u_gudc_counter (
		.hclk       (hclk),
		.hresetn    (hresetn),
		.hsel       (hsel),
		.haddr      (haddr),
		.htrans     (htrans),
		.hwrite     (hwrite),
		.hsize      (hsize),
		.hwdata     (hwdata),
		.hready     (hreadyout),
		.hrdata     (hrdata),
		.hreadyout  (hreadyout),
		.hresp      (hresp),
		.src_pin    (src_pin),
		.gate_pin   (gate_pin),
		.updn_pin   (updn_pin),
		.out_pin    (out_pin),
		.res_data   (res_data),
		.res_vld    (res_vld),
		.stream_req (stream_req)
	);
	gudc_pins u_pins (
		.hclk     (hclk),
		.src_pin  (src_pin),
		.gate_pin (gate_pin),
		.updn_pin (updn_pin)
	);

	// ==========================================================
	// bus and check tasks
	// ==========================================================
	task automatic test_done();
		$display("mismatches %0d, checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : test_done

	task automatic wait_ready();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1)
		begin
			n_mismatch++;
			test_done();
		end
	endtask : wait_ready

	// htrans stays idle at exit so back-to-back calls never assign it twice
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_ready();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		rd = hrdata;
	endtask : bus

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	task automatic rchk(input string what, input logic [2:0] idx, input logic [31:0] exp);
		bus(1'b0, {27'h0, idx, 2'h0}, 32'h0);
		chk(what, exp, rd);
	endtask : rchk

	task automatic wr(input logic [2:0] idx, input logic [31:0] d);
		bus(1'b1, {27'h0, idx, 2'h0}, d);
	endtask : wr

	task automatic rearm(input logic [31:0] load, input logic [31:0] ctl);
		wr(IDX_CTRL, 32'h0);
		wr(IDX_LOAD, load);
		wr(IDX_CTRL, ctl);
	endtask : rearm

	always @(posedge hclk)
		if (res_vld === 1'b1)
			res_seen <= res_data;

	initial
	begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end

	initial
	begin
		#5000000;
		n_mismatch++;
		test_done();
	end

	// ==========================================================
	// scenarios
	// ==========================================================
	initial
	begin
		hresetn    = 1'b0;
		hsel       = 1'b0;
		haddr      = 32'h0;
		htrans     = 2'h0;
		hwrite     = 1'b0;
		hsize      = 3'h2;
		hwdata     = 32'h0;
		res_seen   = 32'h0;
		n_mismatch = 0;
		checks     = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		// unmapped write must not alias onto control
		bus(1'b1, 32'h0000_0020, 32'hffff_ffff);
		rchk("ctrl", IDX_CTRL, RST_WORD);
		rchk("status", IDX_STATUS, 32'h0);
		bus(1'b0, 32'h0000_0020, 32'h0);
		chk("unmapped", 32'h0, rd);
		rearm(32'h5, 32'h11);
		u_pins.src_pulses(3);
		rchk("count up", IDX_COUNT, 32'h8);
		wr(IDX_COUNT, 32'h77);
		rchk("count ro", IDX_COUNT, 32'h8);
		rchk("status run", IDX_STATUS, 32'h6);
		rearm(32'h1, 32'h1);
		u_pins.src_pulses(3);
		rchk("count down", IDX_COUNT, 32'hffff_fffe);
		u_pins.set_dir(1'b1);
		rearm(32'hffff_ffff, 32'h9);
		u_pins.src_pulses(2);
		rchk("hw up wrap", IDX_COUNT, 32'h1);
		u_pins.set_dir(1'b0);
		u_pins.src_pulses(3);
		rchk("hw down wrap", IDX_COUNT, 32'hffff_fffe);
		rearm(32'h0, 32'h91);
		u_pins.src_pulses(2);
		rchk("trig wait", IDX_COUNT, 32'h0);
		u_pins.gate_pulse();
		u_pins.src_pulses(2);
		rchk("trig run", IDX_COUNT, 32'h2);
		// level gating, plain then with the gate pin inverted
		rearm(32'h0, 32'h31);
		u_pins.src_pulses(2);
		rchk("gate closed", IDX_COUNT, 32'h0);
		u_pins.gate_set(1'b1);
		u_pins.src_pulses(2);
		rchk("gate open", IDX_COUNT, 32'h2);
		rearm(32'h0, 32'h431);
		u_pins.src_pulses(1);
		u_pins.gate_set(1'b0);
		u_pins.src_pulses(3);
		rchk("gate inverted", IDX_COUNT, 32'h3);
		rearm(32'h0, 32'h51);
		u_pins.src_pulses(4);
		u_pins.gate_pulse();
		rchk("save", IDX_SAVE, 32'h4);
		chk("result", 32'h4, res_seen);
		chk("no stream", 32'h0, {31'h0, stream_req});
		wr(IDX_CTRL, 32'h851);
		u_pins.src_pulses(2);
		u_pins.gate_pulse();
		chk("stream req", 32'h1, {31'h0, stream_req});
		rchk("save buf", IDX_SAVE, 32'h6);
		rchk("status vld", IDX_STATUS, 32'h16);
		u_pins.src_pulses(1);
		u_pins.gate_pulse();
		rchk("stream", IDX_STREAM, 32'h7);
		rchk("status ovr", IDX_STATUS, 32'h26);
		wr(IDX_STATUS, 32'h20);
		rchk("status clr", IDX_STATUS, 32'h6);
		wr(IDX_CTRL, 32'h0);
		wr(IDX_DELAY, 32'h2);
		wr(IDX_PWIDTH, 32'h3);
		wr(IDX_CTRL, 32'h3);
		u_pins.src_pulses(1);
		chk("out delay", 32'h0, {31'h0, out_pin});
		u_pins.src_pulses(1);
		chk("out rise", 32'h1, {31'h0, out_pin});
		u_pins.src_pulses(2);
		chk("out width", 32'h1, {31'h0, out_pin});
		u_pins.src_pulses(1);
		chk("out fall", 32'h0, {31'h0, out_pin});
		rchk("status done", IDX_STATUS, 32'he);
		wr(IDX_CTRL, 32'h0);
		wr(IDX_CTRL, 32'h183);
		u_pins.src_pulses(3);
		chk("out armed", 32'h0, {31'h0, out_pin});
		repeat (2)
		begin
			u_pins.gate_pulse();
			u_pins.src_pulses(2);
			chk("gated rise", 32'h1, {31'h0, out_pin});
			u_pins.src_pulses(3);
			chk("gated fall", 32'h0, {31'h0, out_pin});
			rchk("status rewait", IDX_STATUS, 32'h2);
		end
		// reset while waiting for a gate edge must drop the armed counter
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		rchk("ctrl reset", IDX_CTRL, RST_WORD);
		rchk("status reset", IDX_STATUS, 32'h0);
		chk("out reset", 32'h0, {31'h0, out_pin});
		test_done();
	end
endmodule : testbench
